// ===== flash_burst_host.sv
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////////
module word_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 32
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic push;
    logic pop;

    assign in_ready = (count != (AW+1)'(DEPTH));
    assign out_valid = (count != '0);
    assign out_data = mem[rd_ptr];
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;

    always_ff @(posedge clock) begin
        if (rst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            if (push) begin
                mem[wr_ptr] <= in_data;
                wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
            end
            count <= count + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

////////////////////////////////////////////////////////////////////////////////
module flash_burst_host #(
    parameter int SUSPEND_LIMIT = flash_burst_pkg::SUSPEND_TIME_LIMIT_CYC
) (
    input wire logic clock,
    input wire logic rst,
    flash_link.host link,
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire logic [flash_burst_pkg::ADDR_W-1:0] cmd_addr,
    input wire logic [7:0] cmd_len,
    input wire logic active_falling,
    input wire logic ready_timing_select,
    input wire logic linear8,
    output logic rd_valid,
    input wire logic rd_ready,
    output logic [flash_burst_pkg::DATA_W-1:0] rd_data,
    output logic suspended
);
    flash_burst_pkg::host_state_e state;
    flash_burst_pkg::host_state_e next_state;
    logic [10:0] hold_cnt;
    logic [10:0] next_hold_cnt;
    logic [24:0] susp_cnt;
    logic [24:0] next_susp_cnt;
    logic clk_q, next_clk_q;
    logic ce_n_q, next_ce_n_q;
    logic avd_n_q, next_avd_n_q;
    logic reset_n_q, next_reset_n_q;
    logic rdy_seen, next_rdy_seen;
    logic [flash_burst_pkg::ADDR_W-1:0] cur_addr, next_cur_addr;
    logic [7:0] remain, next_remain;
    logic idle_level;
    logic take;
    logic fifo_ready;

    word_fifo #(.WIDTH(flash_burst_pkg::FIFO_WIDTH), .DEPTH(flash_burst_pkg::FIFO_DEPTH)) word_fifo_inst (
        .clock(clock),
        .rst(rst),
        .in_valid(take),
        .in_ready(fifo_ready),
        .in_data(link.data),
        .out_valid(rd_valid),
        .out_ready(rd_ready),
        .out_data(rd_data)
    );

    always_comb begin
        idle_level = active_falling;
        next_state = state;
        next_hold_cnt = hold_cnt;
        next_susp_cnt = susp_cnt;
        next_clk_q = clk_q;
        next_ce_n_q = ce_n_q;
        next_avd_n_q = avd_n_q;
        next_reset_n_q = reset_n_q;
        next_rdy_seen = rdy_seen;
        next_cur_addr = cur_addr;
        next_remain = remain;
        take = 1'b0;
        case (state)
            flash_burst_pkg::HOST_HOLD: begin
                next_reset_n_q = 1'b0;
                // Hold reset low long enough before any access
                if (hold_cnt == 11'(flash_burst_pkg::POWERUP_RESET_HOLD_CYC - 1)) begin
                    next_reset_n_q = 1'b1;
                    next_state = flash_burst_pkg::HOST_IDLE;
                end else begin
                    next_hold_cnt = hold_cnt + 11'h1;
                end
            end
            flash_burst_pkg::HOST_IDLE: begin
                next_clk_q = idle_level;
                if (cmd_valid && cmd_len != 8'h0) begin
                    next_cur_addr = cmd_addr;
                    next_remain = cmd_len;
                    next_ce_n_q = 1'b0;
                    next_avd_n_q = 1'b0;
                    next_state = flash_burst_pkg::HOST_ADDR;
                end
            end
            flash_burst_pkg::HOST_ADDR: begin
                next_clk_q = ~clk_q;
                if (clk_q != idle_level) begin
                    next_avd_n_q = 1'b1;
                    next_rdy_seen = 1'b0;
                    next_state = flash_burst_pkg::HOST_RUN;
                end
            end
            flash_burst_pkg::HOST_RUN: begin
                if (clk_q != idle_level) begin
                    next_clk_q = idle_level;
                end else if (!fifo_ready) begin
                    // Full buffer stops the clock; the device holds its word
                    next_susp_cnt = susp_cnt + 25'h1;
                    if (susp_cnt == 25'(SUSPEND_LIMIT - 1)) begin
                        next_ce_n_q = 1'b1;
                        next_state = flash_burst_pkg::HOST_RESTART;
                    end
                end else begin
                    next_susp_cnt = 25'h0;
                    next_clk_q = ~idle_level;
                    next_rdy_seen = link.ready;
                    take = ready_timing_select ? link.ready : rdy_seen;
                    if (take) begin
                        next_remain = remain - 8'h1;
                        next_cur_addr = linear8
                            ? {cur_addr[flash_burst_pkg::ADDR_W-1:3], 3'(cur_addr[2:0] + 3'h1)}
                            : cur_addr + 22'h1;
                        if (remain == 8'h1) begin
                            // No edge past the last word; the clock parks with the frame
                            next_clk_q = idle_level;
                            next_ce_n_q = 1'b1;
                            next_state = flash_burst_pkg::HOST_IDLE;
                        end
                    end
                end
            end
            flash_burst_pkg::HOST_RESTART: begin
                // Fresh address phase picks up at the next word owed
                next_susp_cnt = 25'h0;
                if (fifo_ready) begin
                    next_ce_n_q = 1'b0;
                    next_avd_n_q = 1'b0;
                    next_state = flash_burst_pkg::HOST_ADDR;
                end
            end
            default: begin
                next_state = flash_burst_pkg::HOST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            state <= flash_burst_pkg::HOST_HOLD;
            hold_cnt <= 11'h0;
            susp_cnt <= 25'h0;
            clk_q <= 1'b0;
            ce_n_q <= 1'b1;
            avd_n_q <= 1'b1;
            reset_n_q <= 1'b0;
            rdy_seen <= 1'b0;
            cur_addr <= '0;
            remain <= 8'h0;
        end else begin
            state <= next_state;
            hold_cnt <= next_hold_cnt;
            susp_cnt <= next_susp_cnt;
            clk_q <= next_clk_q;
            ce_n_q <= next_ce_n_q;
            avd_n_q <= next_avd_n_q;
            reset_n_q <= next_reset_n_q;
            rdy_seen <= next_rdy_seen;
            cur_addr <= next_cur_addr;
            remain <= next_remain;
        end
    end

    assign link.flash_clk = clk_q;
    assign link.reset_n = reset_n_q;
    assign link.ce_n = ce_n_q;
    assign link.oe_n = ce_n_q;
    assign link.addr_valid_strobe_n = avd_n_q;
    assign link.addr = cur_addr;
    assign cmd_ready = (state == flash_burst_pkg::HOST_IDLE);
    assign suspended = (state == flash_burst_pkg::HOST_RUN) && (clk_q == idle_level) && !fifo_ready;
endmodule

// ===== flash_burst_pkg.sv
package flash_burst_pkg;
    localparam int ADDR_W = 22;
    localparam int DATA_W = 16;
    localparam logic [2:0] WAIT_MIN = 3'h2;
    localparam logic [2:0] WAIT_MAX = 3'h7;
    localparam logic [5:0] BOUNDARY_LAST = 6'h3f;
    localparam logic [3:0] STALL_EDGES = 4'h2;
    localparam int FIFO_WIDTH = 16;
    localparam int FIFO_DEPTH = 32;
    localparam int CLOCK_MHZ = 25;
    localparam int POWERUP_RESET_HOLD_US = 50;
    localparam int POWERUP_RESET_HOLD_CYC = POWERUP_RESET_HOLD_US * CLOCK_MHZ;
    localparam int SUSPEND_TIME_LIMIT_MS = 1;
    localparam int SUSPEND_TIME_LIMIT_CYC = SUSPEND_TIME_LIMIT_MS * 1000 * CLOCK_MHZ;

    typedef enum logic [3:0] {
        DEV_IDLE = 4'h1,
        DEV_WAIT = 4'h2,
        DEV_BURST = 4'h4,
        DEV_STALL = 4'h8
    } dev_state_e;

    typedef enum logic [4:0] {
        HOST_HOLD = 5'h01,
        HOST_IDLE = 5'h02,
        HOST_ADDR = 5'h04,
        HOST_RUN = 5'h08,
        HOST_RESTART = 5'h10
    } host_state_e;
endpackage

// ===== flash_link.sv
`timescale 1ns/100ps
interface flash_link;
    logic flash_clk;
    logic reset_n;
    logic ce_n;
    logic oe_n;
    logic addr_valid_strobe_n;
    logic [flash_burst_pkg::ADDR_W-1:0] addr;
    logic [flash_burst_pkg::DATA_W-1:0] data;
    logic data_oe;
    logic ready;

    modport device (
        input flash_clk, reset_n, ce_n, oe_n, addr_valid_strobe_n, addr,
        output data, data_oe, ready
    );
    modport host (
        output flash_clk, reset_n, ce_n, oe_n, addr_valid_strobe_n, addr,
        input data, data_oe, ready
    );
endinterface

// ===== flash_burst_device.sv
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////////
// What this block does
// - Initial wait settable from two to seven
// - Two stall edges after 64-word boundary
// - Ready low only in initial wait and boundary stall
// - Address taken on first active edge or strobe
// - Active clock edge rising or falling
// - Timing bit one: ready with data
// - Timing bit zero: ready one edge early
// - Linear eight burst wraps in aligned range
// - Reduced handshake even start is faster
// - Host suspends no longer than one millisecond
// - Burst resumes at stopped word
// - Data released when chip or output disabled
// - Host holds reset low fifty microseconds
// - Read mode leaves program path untouched
module flash_burst_device (
    input wire logic clock,
    input wire logic rst,
    flash_link.device link,
    output logic [flash_burst_pkg::ADDR_W-1:0] mem_addr,
    input wire logic [flash_burst_pkg::DATA_W-1:0] mem_data,
    input wire logic [2:0] wait_states,
    input wire logic active_falling,
    input wire logic ready_timing_select,
    input wire logic reduced_handshake,
    input wire logic linear8,
    input wire logic sync_mode,
    output logic busy
);
    ////////////////////////////////////////////////////////////////////////////
    flash_burst_pkg::dev_state_e state;
    flash_burst_pkg::dev_state_e next_state;
    logic [flash_burst_pkg::ADDR_W-1:0] addr;
    logic [flash_burst_pkg::ADDR_W-1:0] next_addr;
    logic [flash_burst_pkg::DATA_W-1:0] data_q;
    logic [flash_burst_pkg::DATA_W-1:0] next_data_q;
    logic [3:0] cnt;
    logic [3:0] next_cnt;
    logic captured;
    logic next_captured;
    logic clk_prev;
    logic avd_prev_n;
    logic active_edge;
    logic avd_rise;
    logic capture;
    logic crossing;
    logic [2:0] ws_eff;
    logic [3:0] latency;
    logic [flash_burst_pkg::ADDR_W-1:0] step_addr;
    logic valid_now;
    logic valid_next;

    ////////////////////////////////////////////////////////////////////////////
    // Edge and strobe detection on the sampled pins
    always_ff @(posedge clock) begin
        if (rst) begin
            clk_prev <= 1'b0;
            avd_prev_n <= 1'b1;
        end else begin
            clk_prev <= link.flash_clk;
            avd_prev_n <= link.addr_valid_strobe_n;
        end
    end

    always_comb begin
        if (active_falling) begin
            active_edge = clk_prev & ~link.flash_clk;
        end else begin
            active_edge = ~clk_prev & link.flash_clk;
        end
        avd_rise = ~avd_prev_n & link.addr_valid_strobe_n;
        // Only the first of edge and strobe rise may start a burst
        capture = sync_mode & ~captured & ((active_edge & ~link.addr_valid_strobe_n) | avd_rise);
    end

    ////////////////////////////////////////////////////////////////////////////
    // Latency and address stepping
    always_comb begin
        if (wait_states < flash_burst_pkg::WAIT_MIN) begin
            ws_eff = flash_burst_pkg::WAIT_MIN;
        end else begin
            ws_eff = wait_states;
        end
        // Odd start or standard handshake costs one more edge
        if (reduced_handshake && !link.addr[0]) begin
            latency = {1'b0, ws_eff};
        end else begin
            latency = {1'b0, ws_eff} + 4'h1;
        end
        if (linear8) begin
            step_addr = {addr[flash_burst_pkg::ADDR_W-1:3], 3'(addr[2:0] + 3'h1)};
        end else begin
            step_addr = addr + 22'h1;
        end
        // A wrapping linear burst never leaves its range, so no stall
        crossing = ~linear8 & (addr[5:0] == flash_burst_pkg::BOUNDARY_LAST);
    end

    ////////////////////////////////////////////////////////////////////////////
    // Burst sequencer
    always_comb begin
        next_state = state;
        next_addr = addr;
        next_cnt = cnt;
        next_data_q = data_q;
        next_captured = capture | (captured & ~link.addr_valid_strobe_n);
        mem_addr = addr;
        if (state == flash_burst_pkg::DEV_BURST) begin
            mem_addr = step_addr;
        end
        if (!link.reset_n || link.ce_n) begin
            next_state = flash_burst_pkg::DEV_IDLE;
            next_captured = 1'b0;
        end else if (!sync_mode) begin
            // Asynchronous read: strobe rise latches, word follows
            next_state = flash_burst_pkg::DEV_IDLE;
            if (avd_rise) begin
                next_addr = link.addr;
            end
            next_data_q = mem_data;
        end else if (capture) begin
            next_addr = link.addr;
            next_cnt = latency;
            next_state = flash_burst_pkg::DEV_WAIT;
        end else if (active_edge) begin
            // No edge means the burst simply holds its place
            case (state)
                flash_burst_pkg::DEV_IDLE: begin
                    next_state = flash_burst_pkg::DEV_IDLE;
                end
                flash_burst_pkg::DEV_WAIT: begin
                    if (cnt <= 4'h1) begin
                        next_state = flash_burst_pkg::DEV_BURST;
                        next_data_q = mem_data;
                    end else begin
                        next_cnt = cnt - 4'h1;
                    end
                end
                flash_burst_pkg::DEV_BURST: begin
                    next_addr = step_addr;
                    if (crossing) begin
                        next_state = flash_burst_pkg::DEV_STALL;
                        next_cnt = flash_burst_pkg::STALL_EDGES;
                    end else begin
                        next_data_q = mem_data;
                    end
                end
                flash_burst_pkg::DEV_STALL: begin
                    if (cnt <= 4'h1) begin
                        next_state = flash_burst_pkg::DEV_BURST;
                        next_data_q = mem_data;
                    end else begin
                        next_cnt = cnt - 4'h1;
                    end
                end
                default: begin
                    next_state = flash_burst_pkg::DEV_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            state <= flash_burst_pkg::DEV_IDLE;
            addr <= '0;
            cnt <= 4'h0;
            data_q <= '0;
            captured <= 1'b0;
        end else begin
            state <= next_state;
            addr <= next_addr;
            cnt <= next_cnt;
            data_q <= next_data_q;
            captured <= next_captured;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Ready and data pins
    always_comb begin
        valid_now = (state == flash_burst_pkg::DEV_BURST);
        valid_next = (state == flash_burst_pkg::DEV_BURST && !crossing)
            || ((state == flash_burst_pkg::DEV_WAIT || state == flash_burst_pkg::DEV_STALL) && cnt <= 4'h1);
        if (state == flash_burst_pkg::DEV_IDLE || !sync_mode) begin
            link.ready = 1'b1;
        end else if (ready_timing_select) begin
            link.ready = valid_now;
        end else begin
            link.ready = valid_next;
        end
    end

    // The read mode only steers this read path; nothing here writes the array
    assign link.data = data_q;
    assign link.data_oe = link.reset_n & ~link.ce_n & ~link.oe_n;
    assign busy = (state != flash_burst_pkg::DEV_IDLE);
endmodule

// ===== flash_link_asserts.sv
`timescale 1ns/100ps
module flash_link_checker #(
    parameter int SUSPEND_LIMIT = 40
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic flash_clk,
    input wire logic reset_n,
    input wire logic ce_n,
    input wire logic oe_n,
    input wire logic addr_valid_strobe_n,
    input wire logic [flash_burst_pkg::ADDR_W-1:0] addr,
    input wire logic [flash_burst_pkg::DATA_W-1:0] data,
    input wire logic data_oe,
    input wire logic ready
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);

    logic [15:0] hold_cnt;
    logic [15:0] next_hold_cnt;
    logic [15:0] still_cnt;
    logic [15:0] next_still_cnt;
    logic clk_prev;

    // Saturating, so a long idle spell cannot wrap into a false pass
    always_comb begin
        next_hold_cnt = hold_cnt;
        if (!reset_n && hold_cnt != 16'hffff) begin
            next_hold_cnt = hold_cnt + 16'h0001;
        end
        next_still_cnt = 16'h0000;
        if (!ce_n && flash_clk == clk_prev && still_cnt != 16'hffff) begin
            next_still_cnt = still_cnt + 16'h0001;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            hold_cnt <= 16'h0000;
            still_cnt <= 16'h0000;
        end else begin
            hold_cnt <= next_hold_cnt;
            still_cnt <= next_still_cnt;
        end
        clk_prev <= flash_clk;
    end

    ////////////////////////////////////////////////////////////////////////////
    oe_release_a: assert property (data_oe == (reset_n && !ce_n && !oe_n))
        else $error("data bus enable mismatch");
    reset_hold_a: assert property ($rose(reset_n) |-> hold_cnt >= 16'h04e2 && hold_cnt <= 16'h04e4)
        else $error("device reset hold wrong length");
    reset_idle_a: assert property (!reset_n |-> ce_n)
        else $error("access during device reset");
    // Strobe spans the parked cycle and the first active edge
    strobe_pulse_a: assert property ($fell(addr_valid_strobe_n) |=> !addr_valid_strobe_n ##1 addr_valid_strobe_n)
        else $error("address strobe not two cycles");
    strobe_select_a: assert property (!addr_valid_strobe_n |-> !ce_n && reset_n)
        else $error("address strobe without chip enable");
    suspend_limit_a: assert property (int'(still_cnt) <= SUSPEND_LIMIT + 4)
        else $error("clock held too long");
    idle_ready_a: assert property (ce_n ##1 ce_n |-> ready)
        else $error("ready low while deselected");
    ready_back_a: assert property ($fell(ready) |-> ##[1:200] ready)
        else $error("ready stuck low");
    // A new edge setting may move the parked level once; a running clock would move again
    idle_clock_a: assert property (ce_n && $changed(flash_clk) |=> $stable(flash_clk))
        else $error("link clock runs while idle");
    enable_pair_a: assert property (oe_n == ce_n)
        else $error("output enable apart from chip enable");

    cover property ($fell(ready) && !ce_n);
    cover property (int'(still_cnt) == SUSPEND_LIMIT);
    cover property ($rose(addr_valid_strobe_n));
endmodule

// ===== flash_sync_burst_read_port_tb.sv
`timescale 1ns/100ps
module flash_sync_burst_read_port_tb;
    logic clock, rst, cmd_valid, cmd_ready, rd_valid, rd_ready, suspended, busy;
    logic active_falling, ready_timing_select, reduced_handshake, linear8;
    logic [2:0] wait_states;
    logic [7:0] cmd_len;
    logic [21:0] cmd_addr, mem_addr;
    logic [15:0] rd_data, mem_data;
    int fail_count, cmp_count, lat, dur, lows, waited;

    flash_link link();
    // Array contents derived from the low 16 address bits so every word within a 64K span is distinct
    assign mem_data = mem_addr[15:0] ^ 16'ha5c3;

    flash_burst_device flash_burst_device_inst (.clock(clock), .rst(rst), .link(link), .mem_addr(mem_addr),
        .mem_data(mem_data), .wait_states(wait_states), .active_falling(active_falling),
        .ready_timing_select(ready_timing_select), .reduced_handshake(reduced_handshake), .linear8(linear8),
        .sync_mode(1'b1), .busy(busy));
    flash_burst_host #(.SUSPEND_LIMIT(40)) flash_burst_host_inst (.clock(clock), .rst(rst), .link(link),
        .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_addr(cmd_addr), .cmd_len(cmd_len),
        .active_falling(active_falling), .ready_timing_select(ready_timing_select), .linear8(linear8),
        .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_data(rd_data), .suspended(suspended));
    flash_link_checker #(.SUSPEND_LIMIT(40)) flash_link_checker_inst (.clock(clock), .rst(rst),
        .flash_clk(link.flash_clk), .reset_n(link.reset_n), .ce_n(link.ce_n), .oe_n(link.oe_n),
        .addr_valid_strobe_n(link.addr_valid_strobe_n), .addr(link.addr), .data(link.data),
        .data_oe(link.data_oe), .ready(link.ready));

    ////////////////////////////////////////////////////////////////////////////
    task automatic close_out;
        $display("compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value %s expected %0h seen %0h", name, exp, seen);
        end
    endtask

    task automatic wait_idle(input int limit);
        waited = 0;
        while (cmd_ready !== 1'b1 && waited < limit) begin
            @(posedge clock);
            #1;
            waited++;
        end
        if (waited >= limit) begin
            check("command ready wait", 0, 1);
            close_out();
        end
    endtask

    task automatic setup(input logic f, input logic r, input logic [2:0] w, input logic red, input logic l8);
        @(posedge clock);
        active_falling <= f;
        ready_timing_select <= r;
        wait_states <= w;
        reduced_handshake <= red;
        linear8 <= l8;
    endtask

    // One burst; a nonzero stall holds the reader off until more than stall cycles have passed since the host first suspended
    task automatic burst(input logic [21:0] a, input int n, input int stall);
        int k, s;
        logic [21:0] ea;
        k = 0;
        s = 0;
        lows = 0;
        dur = 0;
        @(posedge clock);
        cmd_addr <= a;
        cmd_len <= n[7:0];
        cmd_valid <= 1'b1;
        rd_ready <= (stall == 0);
        @(posedge clock);
        cmd_valid <= 1'b0;
        while (k < n && dur < 3000) begin
            @(posedge clock);
            if (s > stall) rd_ready <= 1'b1;
            #1;
            dur++;
            if (suspended === 1'b1 || s > 0) s++;
            if (link.ready === 1'b0 && link.ce_n === 1'b0 && k > 0) lows++;
            if (rd_valid === 1'b1 && rd_ready === 1'b1) begin
                ea = linear8 ? {a[21:3], a[2:0] + k[2:0]} : a + k[21:0];
                check("burst word", rd_data, ea[15:0] ^ 16'ha5c3);
                if (k == 0) lat = dur;
                k++;
            end
        end
        if (k < n) begin
            check("burst finish", 0, 1);
            close_out();
        end
        if (stall > 0) check("host suspended", s > 0, 1);
        wait_idle(200);
        check("bus released", link.data_oe, 1'b0);
        // Device drops to idle one cycle after the deselect
        @(posedge clock);
        #1;
        check("device idle", busy, 1'b0);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic latency_sweep;
        int le, prev;
        prev = 0;
        for (int f = 0; f < 2; f++) begin
            for (int r = 0; r < 2; r++) begin
                for (int w = 2; w < 8; w++) begin
                    setup(f[0], r[0], w[2:0], 1'b1, 1'b0);
                    burst(22'h000100, 4, 0);
                    le = lat;
                    if (w > 2) check("wait step", le - prev, 2);
                    prev = le;
                    burst(22'h000101, 4, 0);
                    check("odd start latency", lat - le, 2);
                    setup(f[0], r[0], w[2:0], 1'b0, 1'b0);
                    burst(22'h000100, 4, 0);
                    check("standard latency", lat - le, 2);
                end
            end
        end
    endtask

    task automatic boundary_case;
        int d0;
        setup(1'b0, 1'b1, 3'h3, 1'b0, 1'b0);
        burst(22'h000038, 8, 0);
        d0 = dur;
        check("ready low no crossing", lows, 0);
        burst(22'h00003c, 8, 0);
        check("crossing cost", dur - d0, 4);
        check("ready low at crossing", lows > 0, 1);
        setup(1'b1, 1'b0, 3'h4, 1'b0, 1'b1);
        burst(22'h00003e, 8, 0);
        check("wrap never stalls", lows, 0);
    endtask

    // Short hold resumes in place, long hold forces a fresh address
    task automatic suspend_case;
        setup(1'b0, 1'b1, 3'h2, 1'b1, 1'b0);
        burst(22'h000070, 40, 6);
        burst(22'h0000f0, 40, 80);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end

    initial begin
        fail_count = 0;
        cmp_count = 0;
        rst = 1'b1;
        cmd_valid = 1'b0;
        cmd_addr = 22'h000000;
        cmd_len = 8'h00;
        rd_ready = 1'b1;
        active_falling = 1'b0;
        ready_timing_select = 1'b1;
        wait_states = 3'h2;
        reduced_handshake = 1'b0;
        linear8 = 1'b0;
        repeat (11) @(posedge clock);
        #1;
        check("reset_n in reset", link.reset_n, 1'b0);
        check("ce_n in reset", link.ce_n, 1'b1);
        check("data_oe in reset", link.data_oe, 1'b0);
        @(posedge clock);
        rst <= 1'b0;
        wait_idle(2000);
        check("reset hold length", waited >= 1250, 1);
        latency_sweep();
        boundary_case();
        suspend_case();
        close_out();
    end
endmodule
